// ---- core/srr_defines.svh ----
// Constants for the status reporting registers: bit positions, reset values, characters.
// Assumes it is included by bare name from files that need these figures.
`ifndef SRR_DEFINES_SVH
`define SRR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define SRR_BYTE_W          8
`define SRR_RESET_BYTE      8'h00
`define SRR_RSP_CHARS       4

// ----------------------------------------------------------------------------
// Event status latch bit positions
// ----------------------------------------------------------------------------
`define SRR_BIT_POWER_ON    7
`define SRR_BIT_CMD_ERR     5
`define SRR_BIT_EXEC_ERR    4
`define SRR_BIT_OUT_LOSS    2
`define SRR_BIT_OP_DONE     0

// ----------------------------------------------------------------------------
// Summary status byte bit positions
// ----------------------------------------------------------------------------
`define SRR_BIT_REQ_SERVICE 6
`define SRR_BIT_EVT_SUMMARY 5
`define SRR_BIT_MSG_AVAIL   4

// ----------------------------------------------------------------------------
// Characters and digit arithmetic
// ----------------------------------------------------------------------------
`define SRR_LINE_TERMINATOR 8'h0a
`define SRR_ASCII_ZERO      8'h30
`define SRR_CHAR_NONE       8'h00
`define SRR_DIGIT_BASE      8'h0a
`define SRR_HUNDRED         8'h64
`define SRR_OP_DONE_VALUE   8'h01

`endif

// ---- core/srr_pkg.sv ----
// Types shared by the status reporting registers and their formatter.
// Assumes the command parser outside hands over already decoded commands.
package srr_pkg;

    // ------------------------------------------------------------------------
    // Decoded host commands
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        SRR_OP_EVT_MASK_WR,
        SRR_OP_EVT_MASK_RD,
        SRR_OP_EVT_LATCH_RD,
        SRR_OP_DONE_CMD,
        SRR_OP_DONE_RD,
        SRR_OP_SRQ_MASK_WR,
        SRR_OP_SRQ_MASK_RD,
        SRR_OP_STATUS_RD,
        SRR_OP_SELF_TEST_RD,
        SRR_OP_CLEAR_STATUS
    } srr_op_t;

    typedef struct packed {
        logic       valid;
        srr_op_t    op;
        logic [7:0] value;
    } srr_cmd_t;

    typedef struct packed {
        logic cmd_error;
        logic exec_error;
        logic output_loss;
    } srr_evt_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } srr_rsp_t;

endpackage : srr_pkg

// ---- core/srr_evt_latch.sv ----
// Sticky event bits: each set input latches its bit until a clear.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/1ps
module srr_evt_latch #(
    parameter int W = 8
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_clk_en,
    input  wire logic [W-1:0] i_set,
    input  wire logic         i_clear,
    output logic      [W-1:0] o_bits
);

    logic [W-1:0] bits_q;

    // A set in the clearing cycle survives, so no event is lost to a read.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bits_q <= '0;
        end else if (i_clk_en) begin
            bits_q <= (bits_q & ~{W{i_clear}}) | i_set;
        end
    end

    assign o_bits = bits_q;

endmodule : srr_evt_latch

// ---- core/srr_dec_fmt.sv ----
// Turns one byte into decimal characters followed by the line terminator.
// Assumes a single start at a time; starts while busy are ignored.
`timescale 1ns/1ps
`include "srr_defines.svh"
module srr_dec_fmt #(
    parameter int N = `SRR_RSP_CHARS
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_clk_en,
    input  wire logic       i_start,
    input  wire logic [7:0] i_value,
    input  wire logic       i_flush,
    input  wire logic       i_ready,
    output logic            o_valid,
    output logic      [7:0] o_char
);

    logic [7:0] chars_q [N];
    logic [2:0] left_q;
    logic       valid_q;

    function automatic logic [7:0] to_ascii(input logic [7:0] d);
        return `SRR_ASCII_ZERO + d;
    endfunction : to_ascii

    logic [7:0] hund;
    logic [7:0] tens;
    logic [7:0] ones;
    assign hund = i_value / `SRR_HUNDRED;
    assign tens = (i_value / `SRR_DIGIT_BASE) % `SRR_DIGIT_BASE;
    assign ones = i_value % `SRR_DIGIT_BASE;

    // ------------------------------------------------------------------------
    // Character shifter
    // ------------------------------------------------------------------------
    // Leading zeros are suppressed; a zero value still gives one digit.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < N; i++) chars_q[i] <= `SRR_CHAR_NONE;
            left_q  <= 3'd0;
            valid_q <= 1'b0;
        end else if (i_clk_en) begin
            if (i_flush) begin
                left_q  <= 3'd0;
                valid_q <= 1'b0;
            end else if (i_start && !valid_q) begin
                valid_q <= 1'b1;
                if (hund != 8'h00) begin
                    chars_q[0] <= to_ascii(hund);
                    chars_q[1] <= to_ascii(tens);
                    chars_q[2] <= to_ascii(ones);
                    chars_q[3] <= `SRR_LINE_TERMINATOR;
                    left_q     <= 3'd4;
                end else if (tens != 8'h00) begin
                    chars_q[0] <= to_ascii(tens);
                    chars_q[1] <= to_ascii(ones);
                    chars_q[2] <= `SRR_LINE_TERMINATOR;
                    left_q     <= 3'd3;
                end else begin
                    chars_q[0] <= to_ascii(ones);
                    chars_q[1] <= `SRR_LINE_TERMINATOR;
                    left_q     <= 3'd2;
                end
            end else if (valid_q && i_ready) begin
                for (int i = 0; i < N - 1; i++) chars_q[i] <= chars_q[i+1];
                chars_q[N-1] <= `SRR_CHAR_NONE;
                left_q       <= left_q - 3'd1;
                valid_q      <= (left_q > 3'd1);
            end
        end
    end

    assign o_valid = valid_q;
    assign o_char  = chars_q[0];

endmodule : srr_dec_fmt

// ---- core/srr_status_regs.sv ----
// Status reporting registers of the remote command interface.
// Assumes a parser on the same clock hands over decoded commands and takes
// response characters one at a time with valid and ready.
`timescale 1ns/1ps
`include "srr_defines.svh"
module srr_status_regs (
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_clk_en,
    input  wire srr_pkg::srr_cmd_t i_cmd,
    output logic                   o_cmd_ready,
    input  wire srr_pkg::srr_evt_t i_events,
    input  wire logic              i_ops_pending,
    input  wire logic              i_queue_busy,
    input  wire logic              i_test_pass,
    output srr_pkg::srr_rsp_t      o_rsp,
    input  wire logic              i_rsp_ready,
    output logic             [7:0] o_status_byte,
    output logic             [7:0] o_event_status,
    output logic                   o_request_service,
    output logic                   o_flush_output
);

    // ------------------------------------------------------------------------
    // Stored state
    // ------------------------------------------------------------------------
    logic [7:0] event_enable_mask_q;
    logic [7:0] service_request_mask_q;
    logic       power_on_seen_q;
    logic       done_cmd_pend_q;
    logic       done_qry_pend_q;
    logic       ready_q;
    logic [7:0] status_q;
    logic [7:0] latch_view_q;
    logic       req_q;
    logic       flush_q;

    logic [7:0] event_status_latch;
    logic [7:0] summary_status_byte;
    logic [7:0] latch_set;
    logic       latch_clear;
    logic       take;
    logic       fmt_start;
    logic [7:0] fmt_value;
    logic       fmt_valid;
    logic [7:0] fmt_char;
    logic       done_fire;
    logic       clear_cmd;
    logic       event_summary_bit;
    logic       message_available;
    logic       request_service;

    // Command strobes, each high only in the cycle its command is taken.
    logic       wr_event_mask;
    logic       wr_service_mask;
    logic       latch_read;
    logic       done_cmd_take;
    logic       done_qry_take;

    assign take      = i_cmd.valid && ready_q;
    // Decoding once here keeps the op compares out of the register blocks;
    // a taken op without a strobe of its own leaves all of them low.
    always_comb begin
        clear_cmd       = 1'b0;
        wr_event_mask   = 1'b0;
        wr_service_mask = 1'b0;
        latch_read      = 1'b0;
        done_cmd_take   = 1'b0;
        done_qry_take   = 1'b0;

        if (take) begin
            case (i_cmd.op)
                srr_pkg::SRR_OP_CLEAR_STATUS: clear_cmd       = 1'b1;
                srr_pkg::SRR_OP_EVT_MASK_WR:  wr_event_mask   = 1'b1;
                srr_pkg::SRR_OP_SRQ_MASK_WR:  wr_service_mask = 1'b1;
                srr_pkg::SRR_OP_EVT_LATCH_RD: latch_read      = 1'b1;
                srr_pkg::SRR_OP_DONE_CMD:     done_cmd_take   = 1'b1;
                srr_pkg::SRR_OP_DONE_RD:      done_qry_take   = 1'b1;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Event latch
    // ------------------------------------------------------------------------
    // Only the five defined positions have set terms, so the rest stay zero.
    always_comb begin
        latch_set                        = `SRR_RESET_BYTE;
        latch_set[`SRR_BIT_POWER_ON]     = !power_on_seen_q;
        latch_set[`SRR_BIT_CMD_ERR]      = i_events.cmd_error;
        latch_set[`SRR_BIT_EXEC_ERR]     = i_events.exec_error;
        latch_set[`SRR_BIT_OUT_LOSS]     = i_events.output_loss;
        latch_set[`SRR_BIT_OP_DONE]      = done_fire;
    end

    // The read clears in the same cycle that the formatter captures the value.
    assign latch_clear = clear_cmd
                       || latch_read;

    srr_evt_latch #(
        .W (`SRR_BYTE_W)
    ) u_latch (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_set     (latch_set),
        .i_clear   (latch_clear),
        .o_bits    (event_status_latch)
    );

    // The power-on event is raised once, in the first enabled cycle after reset.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            power_on_seen_q <= 1'b0;
        end else if (i_clk_en) begin
            power_on_seen_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            event_enable_mask_q <= `SRR_RESET_BYTE;
        end else if (i_clk_en && wr_event_mask) begin
            event_enable_mask_q <= i_cmd.value;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            service_request_mask_q <= `SRR_RESET_BYTE;
        end else if (i_clk_en && wr_service_mask) begin
            service_request_mask_q <= i_cmd.value;
        end
    end

    // ------------------------------------------------------------------------
    // Summary status byte
    // ------------------------------------------------------------------------
    // A response still in the formatter is itself a queued message.
    assign event_summary_bit = |(event_status_latch & event_enable_mask_q);
    assign message_available = i_queue_busy || fmt_valid;

    always_comb begin
        summary_status_byte                       = `SRR_RESET_BYTE;
        summary_status_byte[`SRR_BIT_EVT_SUMMARY] = event_summary_bit;
        summary_status_byte[`SRR_BIT_MSG_AVAIL]   = message_available;
        request_service = |(summary_status_byte & service_request_mask_q);
        summary_status_byte[`SRR_BIT_REQ_SERVICE] = request_service;
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_q     <= `SRR_RESET_BYTE;
            latch_view_q <= `SRR_RESET_BYTE;
            req_q        <= 1'b0;
        end else if (i_clk_en) begin
            status_q     <= summary_status_byte;
            latch_view_q <= event_status_latch;
            req_q        <= request_service;
        end
    end

    // ------------------------------------------------------------------------
    // Operation-complete tracking
    // ------------------------------------------------------------------------
    // Completion is reported only when the formatter is free and no command is
    // being taken, so two producers never start the formatter together.
    assign done_fire = (done_cmd_pend_q || done_qry_pend_q) && !i_ops_pending
                     && !fmt_valid && !take;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_cmd_pend_q <= 1'b0;
        end else if (i_clk_en) begin
            if (clear_cmd || done_fire) begin
                done_cmd_pend_q <= 1'b0;
            end else if (done_cmd_take) begin
                done_cmd_pend_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_qry_pend_q <= 1'b0;
        end else if (i_clk_en) begin
            if (done_fire) begin
                done_qry_pend_q <= 1'b0;
            end else if (done_qry_take) begin
                done_qry_pend_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------------------
    // Ready drops for at least one cycle after every accepted command; this costs a
    // bubble but lets the formatter state settle before the next decision.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ready_q <= 1'b0;
        end else if (i_clk_en) begin
            ready_q <= !take && !fmt_valid && !done_fire && !done_qry_pend_q;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flush_q <= 1'b0;
        end else if (i_clk_en) begin
            flush_q <= clear_cmd;
        end
    end

    // ------------------------------------------------------------------------
    // Response selection
    // ------------------------------------------------------------------------
    always_comb begin
        fmt_start = 1'b0;
        fmt_value = `SRR_RESET_BYTE;
        if (done_fire) begin
            fmt_start = 1'b1;
            fmt_value = `SRR_OP_DONE_VALUE;
        end else if (take) begin
            case (i_cmd.op)
                srr_pkg::SRR_OP_EVT_MASK_RD: begin
                    fmt_start = 1'b1;
                    fmt_value = event_enable_mask_q;
                end
                srr_pkg::SRR_OP_EVT_LATCH_RD: begin
                    fmt_start = 1'b1;
                    fmt_value = event_status_latch;
                end
                srr_pkg::SRR_OP_SRQ_MASK_RD: begin
                    fmt_start = 1'b1;
                    fmt_value = service_request_mask_q;
                end
                srr_pkg::SRR_OP_STATUS_RD: begin
                    fmt_start = 1'b1;
                    fmt_value = summary_status_byte;
                end
                srr_pkg::SRR_OP_SELF_TEST_RD: begin
                    fmt_start = 1'b1;
                    fmt_value = {7'h00, i_test_pass};
                end
                default: begin
                    fmt_start = 1'b0;
                end
            endcase
        end
    end

    srr_dec_fmt #(
        .N (`SRR_RSP_CHARS)
    ) u_fmt (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_start   (fmt_start),
        .i_value   (fmt_value),
        .i_flush   (clear_cmd),
        .i_ready   (i_rsp_ready),
        .o_valid   (fmt_valid),
        .o_char    (fmt_char)
    );

    assign o_cmd_ready       = ready_q;
    assign o_rsp             = '{valid: fmt_valid, data: fmt_char};
    assign o_status_byte     = status_q;
    assign o_event_status    = latch_view_q;
    assign o_request_service = req_q;
    assign o_flush_output    = flush_q;

endmodule : srr_status_regs

// ---- tb/srr_status_props.sv ----
// Concurrent checks on the ports of the status reporting registers.
// Assumes the clock enable is held high by the surroundings.
`timescale 1ns/1ps
module srr_status_props (
    input wire logic              i_sys_clk,
    input wire logic              i_reset_n,
    input wire srr_pkg::srr_cmd_t i_cmd,
    input wire logic              o_cmd_ready,
    input wire srr_pkg::srr_evt_t i_events,
    input wire logic              i_queue_busy,
    input wire srr_pkg::srr_rsp_t o_rsp,
    input wire logic              i_rsp_ready,
    input wire logic        [7:0] o_status_byte,
    input wire logic        [7:0] o_event_status,
    input wire logic              o_request_service,
    input wire logic              o_flush_output
);
    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    logic take;
    logic is_query;
    logic is_clear;
    assign take = i_cmd.valid && o_cmd_ready;
    assign is_clear = take && (i_cmd.op == srr_pkg::SRR_OP_CLEAR_STATUS);
    assign is_query = take && (i_cmd.op inside {srr_pkg::SRR_OP_EVT_MASK_RD,
        srr_pkg::SRR_OP_EVT_LATCH_RD, srr_pkg::SRR_OP_SRQ_MASK_RD,
        srr_pkg::SRR_OP_STATUS_RD, srr_pkg::SRR_OP_SELF_TEST_RD});

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_unused_bits_zero: assert property (
        o_event_status[6] == 1'b0 && o_event_status[3] == 1'b0 && o_event_status[1] == 1'b0)
        else $error("undefined event bit set");
    a_cmd_err_latch: assert property (i_events.cmd_error |-> ##2 o_event_status[5])
        else $error("command error not latched");
    a_loss_latch: assert property (i_events.output_loss |-> ##2 o_event_status[2])
        else $error("output loss not latched");
    a_request_bit: assert property (
        (o_request_service == o_status_byte[6])
        && (!o_request_service || (|o_status_byte[5:4])))
        else $error("request output differs from status bit 6");
    a_msg_avail: assert property (
        $past(i_queue_busy) && $past(i_reset_n) |-> o_status_byte[4])
        else $error("message available bit low while queue busy");
    a_latch_cleared: assert property (
        (take && i_cmd.op == srr_pkg::SRR_OP_EVT_LATCH_RD && i_events == 3'b000)
        ##1 (i_events == 3'b000) |-> ##1 (o_event_status == 8'h00))
        else $error("event latch not cleared by read");
    a_ready_drop: assert property (take |=> !o_cmd_ready)
        else $error("command port ready right after a take");
    a_query_answer: assert property (is_query |=> o_rsp.valid)
        else $error("query gave no response character");
    a_rsp_hold: assert property (
        o_rsp.valid && !i_rsp_ready |=> o_rsp.valid && $stable(o_rsp.data))
        else $error("response character changed before it was taken");
    a_term_release: assert property (
        o_rsp.valid && i_rsp_ready && o_rsp.data == 8'h0a |-> ##[1:3] o_cmd_ready)
        else $error("port not released after line terminator");
    a_flush_pulse: assert property (is_clear |=> o_flush_output ##1 !o_flush_output)
        else $error("flush pulse missing after clear");
endmodule : srr_status_props

bind srr_status_regs srr_status_props props_u (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_cmd(i_cmd),
    .o_cmd_ready(o_cmd_ready), .i_events(i_events), .i_queue_busy(i_queue_busy),
    .o_rsp(o_rsp), .i_rsp_ready(i_rsp_ready), .o_status_byte(o_status_byte),
    .o_event_status(o_event_status), .o_request_service(o_request_service),
    .o_flush_output(o_flush_output)
);

// ---- tb/srr_host_model.sv ----
// Remote host side: takes response characters and decodes each line.
// Assumes responses are decimal digits closed by a line terminator.
`timescale 1ns/1ps
module srr_host_model (
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_slow,
    input  wire srr_pkg::srr_rsp_t i_rsp,
    output logic                   o_rsp_ready,
    output logic            [15:0] o_msg_val,
    output logic             [3:0] o_msg_len,
    output logic             [7:0] o_msg_cnt
);
    logic [15:0] acc_q;
    logic  [3:0] cnt_q;

    // A slow host stalls every other cycle so held characters get exercised.
    always_ff @(negedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rsp_ready <= 1'b0;
        end else begin
            o_rsp_ready <= i_slow ? !o_rsp_ready : 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            acc_q     <= 16'h0000;
            cnt_q     <= 4'h0;
            o_msg_val <= 16'h0000;
            o_msg_len <= 4'h0;
            o_msg_cnt <= 8'h00;
        end else if (i_rsp.valid && o_rsp_ready) begin
            if (i_rsp.data == 8'h0a) begin
                o_msg_val <= acc_q;
                o_msg_len <= cnt_q + 4'h1;
                o_msg_cnt <= o_msg_cnt + 8'h01;
                acc_q     <= 16'h0000;
                cnt_q     <= 4'h0;
            end else begin
                acc_q <= acc_q * 16'h000a + {8'h00, i_rsp.data - 8'h30};
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule : srr_host_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the status reporting registers.
// Assumes the checker is bound to the design through its own file.
`timescale 1ns/1ps
module tb_top;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_ops_pending = 1'b0;
    logic i_queue_busy = 1'b0;
    logic i_test_pass = 1'b0;
    logic slow = 1'b0;
    srr_pkg::srr_cmd_t i_cmd = '0;
    srr_pkg::srr_evt_t i_events = '0;
    srr_pkg::srr_rsp_t o_rsp;
    logic o_cmd_ready, o_request_service, o_flush_output, rsp_ready;
    logic [7:0] o_status_byte, o_event_status, msg_cnt;
    logic [15:0] msg_val;
    logic [3:0] msg_len;
    int mismatches = 0;
    int n_checks = 0;

    initial begin
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    srr_status_regs dut_u (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_clk_en(1'b1),
        .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .i_events(i_events),
        .i_ops_pending(i_ops_pending), .i_queue_busy(i_queue_busy),
        .i_test_pass(i_test_pass), .o_rsp(o_rsp), .i_rsp_ready(rsp_ready),
        .o_status_byte(o_status_byte), .o_event_status(o_event_status),
        .o_request_service(o_request_service), .o_flush_output(o_flush_output));

    srr_host_model host_u (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_slow(slow),
        .i_rsp(o_rsp), .o_rsp_ready(rsp_ready), .o_msg_val(msg_val), .o_msg_len(msg_len),
        .o_msg_cnt(msg_cnt));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic complete_run();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk

    task automatic timed_out(string name);
        mismatches++;
        $display("FAIL %s expected 1 seen 0", name);
        complete_run();
    endtask : timed_out

    task automatic tick(int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : tick

    // The host waits for ready, presents the command for one cycle and does not wait for the answer.
    task automatic send(srr_pkg::srr_op_t op, logic [7:0] val);
        int i;
        for (i = 0; i < 60 && o_cmd_ready !== 1'b1; i++) tick(1);
        if (i == 60) timed_out("cmd_ready");
        i_cmd = '{valid: 1'b1, op: op, value: val};
        tick(1);
        i_cmd.valid = 1'b0;
    endtask : send

    task automatic wait_msg(logic [7:0] c, logic [15:0] exp);
        int i;
        for (i = 0; i < 100 && msg_cnt === c; i++) tick(1);
        if (i == 100) timed_out("response");
        chk("rsp_value", exp, msg_val);
        chk("rsp_len", (exp < 10) ? 2 : (exp < 100) ? 3 : 4, {12'h000, msg_len});
    endtask : wait_msg

    task automatic ask(srr_pkg::srr_op_t op, logic [15:0] exp);
        logic [7:0] c;
        c = msg_cnt;
        send(op, 8'h00);
        wait_msg(c, exp);
    endtask : ask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_masks();
        logic [7:0] v [4] = '{8'h00, 8'h01, 8'h63, 8'hff};
        foreach (v[k]) begin
            send(srr_pkg::SRR_OP_EVT_MASK_WR, v[k]);
            ask(srr_pkg::SRR_OP_EVT_MASK_RD, {8'h00, v[k]});
            send(srr_pkg::SRR_OP_SRQ_MASK_WR, v[k]);
            ask(srr_pkg::SRR_OP_SRQ_MASK_RD, {8'h00, v[k]});
        end
    endtask : t_masks

    task automatic t_events();
        slow = 1'b1;
        i_events = 3'b111;
        tick(1);
        i_events = 3'b000;
        tick(8);
        chk("event_status", 16'h0034, {8'h00, o_event_status});
        send(srr_pkg::SRR_OP_EVT_MASK_WR, 8'h30);
        send(srr_pkg::SRR_OP_SRQ_MASK_WR, 8'h30);
        i_queue_busy = 1'b1;
        tick(3);
        chk("event_summary", 1, o_status_byte[5]);
        chk("request_service", 1, o_request_service);
        ask(srr_pkg::SRR_OP_STATUS_RD, 16'd112);
        send(srr_pkg::SRR_OP_EVT_MASK_WR, 8'h00);
        send(srr_pkg::SRR_OP_SRQ_MASK_WR, 8'h10);
        tick(3);
        chk("request_msg_only", 1, o_request_service);
        i_queue_busy = 1'b0;
        tick(3);
        chk("msg_avail", 0, o_status_byte[4]);
        chk("request_cleared", 0, o_status_byte[6]);
        ask(srr_pkg::SRR_OP_EVT_LATCH_RD, 16'd52);
        slow = 1'b0;
    endtask : t_events

    task automatic t_done();
        logic [7:0] c;
        i_ops_pending = 1'b1;
        c = msg_cnt;
        send(srr_pkg::SRR_OP_DONE_CMD, 8'h00);
        tick(20);
        chk("done_early", c, msg_cnt);
        i_ops_pending = 1'b0;
        wait_msg(c, 16'd1);
        tick(3);
        chk("done_bit", 1, o_event_status[0]);
        i_ops_pending = 1'b1;
        c = msg_cnt;
        send(srr_pkg::SRR_OP_DONE_RD, 8'h00);
        tick(10);
        chk("stall", 0, o_cmd_ready);
        i_ops_pending = 1'b0;
        wait_msg(c, 16'd1);
    endtask : t_done

    task automatic t_clear();
        logic [7:0] c;
        i_events = 3'b010;
        tick(1);
        i_events = 3'b000;
        i_ops_pending = 1'b1;
        c = msg_cnt;
        send(srr_pkg::SRR_OP_DONE_CMD, 8'h00);
        tick(3);
        send(srr_pkg::SRR_OP_CLEAR_STATUS, 8'h00);
        chk("flush", 1, o_flush_output);
        tick(3);
        chk("latch_cleared", 0, {8'h00, o_event_status});
        i_ops_pending = 1'b0;
        tick(20);
        chk("done_cancelled", c, msg_cnt);
    endtask : t_clear

    initial begin
        tick(2);
        i_reset_n = 1'b1;
        tick(2);
        ask(srr_pkg::SRR_OP_EVT_LATCH_RD, 16'd128);
        ask(srr_pkg::SRR_OP_EVT_LATCH_RD, 16'd0);
        t_masks();
        t_events();
        t_done();
        t_clear();
        i_test_pass = 1'b1;
        ask(srr_pkg::SRR_OP_SELF_TEST_RD, 16'd1);
        i_test_pass = 1'b0;
        ask(srr_pkg::SRR_OP_SELF_TEST_RD, 16'd0);
        complete_run();
    end
endmodule : tb_top
